/* include/sbsc_defines.svh */
// Constants of the burst and sleep controller: widths, timing, offsets and reset values.
`ifndef SBSC_DEFINES_SVH
`define SBSC_DEFINES_SVH

`define SBSC_ADDR_W      4
`define SBSC_LOW_W       2
`define SBSC_DATA_W      32
`define SBSC_BE_W        4
`define SBSC_BYTE_W      8
`define SBSC_DEPTH       16

`define SBSC_CLK_NS      10
`define SBSC_ZZI_CYCLES  2'h2
`define SBSC_ZZR_NS      100
`define SBSC_REC_W       16
`define SBSC_ZZR_CYCLES  (((`SBSC_ZZR_NS) + (`SBSC_CLK_NS) - 1) / (`SBSC_CLK_NS))

`define SBSC_OFF_STATUS  32'h0000_0000
`define SBSC_OFF_RECOV   32'h0000_0004
`define SBSC_RESP_OKAY   2'h0
`define SBSC_RESP_SLVERR 2'h2

`define SBSC_SYNC_W      3
`define SBSC_SYNC_ZZ     0
`define SBSC_SYNC_ORDER  1
`define SBSC_SYNC_FT_N   2
`define SBSC_SYNC_RST    3'h4

`endif

/* include/sbsc_pkg.sv */
// Types shared by the burst and sleep controller modules.
package sbsc_pkg;
	`include "sbsc_defines.svh"

	typedef logic [`SBSC_ADDR_W-1:0] sbsc_addr_t;
	typedef logic [`SBSC_DATA_W-1:0] sbsc_data_t;
	typedef logic [`SBSC_BE_W-1:0]   sbsc_be_t;
	typedef logic [`SBSC_LOW_W-1:0]  sbsc_low_t;

	typedef enum logic [2:0] {
		SBSC_RW_DESEL = 3'h1,
		SBSC_RW_READ  = 3'h2,
		SBSC_RW_WRITE = 3'h4
	} sbsc_rw_e;

	typedef enum logic [3:0] {
		SBSC_SL_ACTIVE  = 4'h1,
		SBSC_SL_ENTER   = 4'h2,
		SBSC_SL_SLEEP   = 4'h4,
		SBSC_SL_RECOVER = 4'h8
	} sbsc_sleep_e;

	typedef struct packed {
		logic [21:0] zero;
		sbsc_low_t   burst_count;
		sbsc_rw_e    rw_state;
		logic        interleaved;
		logic        flow_through;
		logic        entering;
		logic        recovering;
		logic        sleeping;
	} sbsc_status_s;
endpackage

/* include/sbsc_burst_if.sv */
// Link between the control core and the two-bit burst address counter.
`timescale 1ns/10ps
`include "sbsc_defines.svh"
interface sbsc_burst_if;
	logic                   load;
	logic                   step;
	logic                   order;
	logic [`SBSC_LOW_W-1:0] start_low;
	logic [`SBSC_LOW_W-1:0] low_next;
	logic [`SBSC_LOW_W-1:0] count;

	modport ctrl (output load, output step, output order, output start_low,
		input low_next, input count);
	modport counter (input load, input step, input order, input start_low,
		output low_next, output count);
endinterface

/* core/sbsc_burst_counter.sv */
// Two-bit burst counter producing linear or interleaved low address bits.
`timescale 1ns/10ps
module sbsc_burst_counter (
	input  wire logic     aclk,
	input  wire logic     aresetn,
	sbsc_burst_if.counter bus
);
	import sbsc_pkg::*;

	sbsc_low_t start_q;
	sbsc_low_t start_d;
	sbsc_low_t cnt_q;
	sbsc_low_t cnt_d;
	sbsc_low_t cnt_inc;

	always_comb begin
		start_d = start_q;
		cnt_d   = cnt_q;
		if (bus.load) begin
			start_d = bus.start_low;
			cnt_d   = '0;
		end else if (bus.step) begin
			cnt_d = cnt_inc;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			start_q <= '0;
			cnt_q   <= '0;
		end else begin
			start_q <= start_d;
			cnt_q   <= cnt_d;
		end
	end

	// The counter wraps by its own width, so the fifth access lands on the start again.
	assign cnt_inc      = cnt_q + sbsc_low_t'(1);
	assign bus.low_next = bus.order ? (start_q ^ cnt_inc)
		: (start_q + cnt_inc);
	assign bus.count    = cnt_q;
endmodule // sbsc_burst_counter

/* core/sbsc_top.sv */
// Burst address and sleep control of a synchronous SRAM, with an AXI4-Lite status port.
// What this block does
// - Advance high on an enabled edge steps the counter and uses its address.
// - Advance low on an enabled edge loads the external address as burst start.
// - The burst covers four addresses and wraps to the start on the fifth.
// - Order pin low gives linear order, low bits counting up modulo four.
// - Order pin high gives interleaved order, start XOR the access count.
// - Sleep pin low means active, high means standby; reset default is low.
// - Mode pin high or open selects pipelined, low selects flow-through.
// - Sleep is entered two cycles after the synchronised request level rises; state is kept.
// - While sleeping, commands are ignored and the data bus is not driven.
// - The sleep request is asynchronous and sleep lasts while it is high.
// - After recovery time the device resumes with its preserved state.
// - A hold edge freezes both the control and data pipeline state.
// - Pipelined write data is taken at the third edge from the command.
// - Flow-through write data is taken at the second edge from the command.
// - During a hold the block stalls and a pipelined read keeps driving.
`timescale 1ns/10ps
`include "sbsc_defines.svh"
module sbsc_top (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic [31:0]        s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [31:0]        s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	input  wire sbsc_pkg::sbsc_addr_t sram_addr,
	input  wire logic               advance_or_load,
	input  wire logic               clk_enable_n,
	input  wire logic               chip_en1_n,
	input  wire logic               chip_en2,
	input  wire logic               chip_en3_n,
	input  wire logic               write_en_n,
	input  wire sbsc_pkg::sbsc_be_t byte_write_n,
	input  wire sbsc_pkg::sbsc_data_t dq_in,
	output sbsc_pkg::sbsc_data_t    dq_out,
	output logic                    dq_oe,
	input  wire logic               sleep_request,
	input  wire logic               burst_order_select,
	input  wire logic               flow_through_select_n
);
	import sbsc_pkg::*;

	sbsc_burst_if burst ();

	sbsc_burst_counter u_counter (
		.aclk    (aclk),
		.aresetn (aresetn),
		.bus     (burst)
	);

	// Pin synchronisers: three stages, a level counts once stages two and three agree.
	logic [`SBSC_SYNC_W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d, agree;
	always_comb begin
		agree = ~(s2_q ^ s3_q);
		lvl_d = (agree & s3_q) | (~agree & lvl_q);
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q  <= `SBSC_SYNC_RST;
			s2_q  <= `SBSC_SYNC_RST;
			s3_q  <= `SBSC_SYNC_RST;
			lvl_q <= `SBSC_SYNC_RST;
		end else begin
			s1_q  <= {flow_through_select_n, burst_order_select, sleep_request};
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	logic zz_lvl, interleaved, flow_through;
	assign zz_lvl       = lvl_q[`SBSC_SYNC_ZZ];
	assign interleaved  = lvl_q[`SBSC_SYNC_ORDER];
	assign flow_through = ~lvl_q[`SBSC_SYNC_FT_N];

	// Sleep sequencing. It never stalls on the clock enable, since sleep ignores it.
	sbsc_sleep_e sl_q, sl_d;
	logic [1:0] ent_q, ent_d;
	logic [`SBSC_REC_W-1:0] rec_q, rec_d, recov_q, recov_d;
	always_comb begin
		sl_d  = sl_q;
		ent_d = ent_q;
		rec_d = rec_q;
		case (sl_q)
			SBSC_SL_ACTIVE: begin
				if (zz_lvl) begin
					sl_d  = SBSC_SL_ENTER;
					ent_d = 2'h1;
				end
			end
			SBSC_SL_ENTER: begin
				if (!zz_lvl) begin
					sl_d = SBSC_SL_ACTIVE;
				end else if (ent_q == `SBSC_ZZI_CYCLES - 2'h1) begin
					sl_d = SBSC_SL_SLEEP;
				end else begin
					ent_d = ent_q + 2'h1;
				end
			end
			SBSC_SL_SLEEP: begin
				if (!zz_lvl) begin
					sl_d  = SBSC_SL_RECOVER;
					rec_d = '0;
				end
			end
			SBSC_SL_RECOVER: begin
				rec_d = rec_q + `SBSC_REC_W'(1);
				if (zz_lvl) begin
					sl_d = SBSC_SL_SLEEP;
				end else if (rec_d >= recov_q) begin
					sl_d = SBSC_SL_ACTIVE;
				end
			end
			default: sl_d = SBSC_SL_ACTIVE;
		endcase
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sl_q  <= SBSC_SL_ACTIVE;
			ent_q <= '0;
			rec_q <= '0;
		end else begin
			sl_q  <= sl_d;
			ent_q <= ent_d;
			rec_q <= rec_d;
		end
	end

	// Command decode. A hold edge leaves every piece of pipeline state alone; sleep does too, except that it clears dq_oe.
	logic run, sel, any_be, recovering, refuse, cur_rd, cur_wr;
	sbsc_rw_e rw_q, rw_d;
	sbsc_addr_t upper_q, upper_d, cur_addr;
	always_comb begin
		run        = !clk_enable_n && (sl_q != SBSC_SL_SLEEP);
		sel        = !chip_en1_n && chip_en2 && !chip_en3_n;
		any_be     = ~&byte_write_n;
		recovering = (sl_q == SBSC_SL_RECOVER);
		// Writes arriving while recovering are dropped rather than risk the array.
		refuse     = recovering && !write_en_n;
		rw_d       = rw_q;
		upper_d    = upper_q;
		cur_rd     = 1'b0;
		cur_wr     = 1'b0;
		cur_addr   = {upper_q[`SBSC_ADDR_W-1:`SBSC_LOW_W], burst.low_next};
		if (run && !advance_or_load) begin
			cur_addr = sram_addr;
			if (sel && !refuse) begin
				upper_d = sram_addr;
				rw_d    = write_en_n ? SBSC_RW_READ : SBSC_RW_WRITE;
				cur_rd  = write_en_n;
				cur_wr  = !write_en_n && any_be;
			end else begin
				rw_d = SBSC_RW_DESEL;
			end
		end else if (run) begin
			cur_rd = (rw_q == SBSC_RW_READ);
			cur_wr = (rw_q == SBSC_RW_WRITE) && any_be && !recovering;
		end
		burst.load      = run && !advance_or_load && sel && !refuse;
		burst.step      = run && advance_or_load;
		burst.order     = interleaved;
		burst.start_low = sram_addr[`SBSC_LOW_W-1:0];
	end

	// Data pipeline: stage one holds the command edge, stage two the edge after it.
	logic s1_rd_q, s1_rd_d, s1_wr_q, s1_wr_d, s2_wr_q, s2_wr_d;
	sbsc_addr_t s1_addr_q, s1_addr_d, s2_addr_q, s2_addr_d;
	sbsc_be_t s1_be_q, s1_be_d, s2_be_q, s2_be_d;
	sbsc_data_t mem [`SBSC_DEPTH];
	sbsc_data_t out_q, out_d;
	logic oe_q, oe_d, mem_we;
	sbsc_addr_t mem_waddr;
	sbsc_be_t mem_be;
	always_comb begin
		s1_rd_d   = s1_rd_q;
		s1_wr_d   = s1_wr_q;
		s1_addr_d = s1_addr_q;
		s1_be_d   = s1_be_q;
		s2_wr_d   = s2_wr_q;
		s2_addr_d = s2_addr_q;
		s2_be_d   = s2_be_q;
		out_d     = out_q;
		oe_d      = oe_q;
		mem_we    = 1'b0;
		mem_waddr = s1_addr_q;
		mem_be    = s1_be_q;
		if (run) begin
			s1_rd_d   = cur_rd;
			s1_wr_d   = cur_wr;
			s1_addr_d = cur_addr;
			s1_be_d   = ~byte_write_n;
			s2_wr_d   = s1_wr_q;
			s2_addr_d = s1_addr_q;
			s2_be_d   = s1_be_q;
			if (flow_through) begin
				mem_we = s1_wr_q;
				out_d  = mem[cur_addr];
				oe_d   = cur_rd;
			end else begin
				mem_we    = s2_wr_q;
				mem_waddr = s2_addr_q;
				mem_be    = s2_be_q;
				out_d     = mem[s1_addr_q];
				oe_d      = s1_rd_q;
			end
		end else if (sl_q == SBSC_SL_SLEEP) begin
			oe_d = 1'b0;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_rd_q   <= 1'b0;
			s1_wr_q   <= 1'b0;
			s1_addr_q <= '0;
			s1_be_q   <= '0;
			s2_wr_q   <= 1'b0;
			s2_addr_q <= '0;
			s2_be_q   <= '0;
			out_q     <= '0;
			oe_q      <= 1'b0;
			rw_q      <= SBSC_RW_DESEL;
			upper_q   <= '0;
		end else begin
			s1_rd_q   <= s1_rd_d;
			s1_wr_q   <= s1_wr_d;
			s1_addr_q <= s1_addr_d;
			s1_be_q   <= s1_be_d;
			s2_wr_q   <= s2_wr_d;
			s2_addr_q <= s2_addr_d;
			s2_be_q   <= s2_be_d;
			out_q     <= out_d;
			oe_q      <= oe_d;
			rw_q      <= rw_d;
			upper_q   <= upper_d;
		end
	end
	// The array holds data only and is left uninitialised on reset.
	always_ff @(posedge aclk) begin
		for (int b = 0; b < `SBSC_BE_W; b++) begin
			if (mem_we && mem_be[b]) begin
				mem[mem_waddr][b*`SBSC_BYTE_W +: `SBSC_BYTE_W] <= dq_in[b*`SBSC_BYTE_W +: `SBSC_BYTE_W];
			end
		end
	end
	assign dq_out = out_q;
	assign dq_oe  = oe_q;

	// AXI4-Lite slave: status read-only, recovery length read-write.
	logic aw_got_q, aw_got_d, w_got_q, w_got_d, bvalid_q, bvalid_d, awready_q, awready_d;
	logic wready_q, wready_d, arready_q, arready_d, rvalid_q, rvalid_d;
	logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d, rdata_q, rdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
	sbsc_status_s status;
	always_comb begin
		status              = '0;
		status.burst_count  = burst.count;
		status.rw_state     = rw_q;
		status.interleaved  = interleaved;
		status.flow_through = flow_through;
		status.entering     = (sl_q == SBSC_SL_ENTER);
		status.recovering   = recovering;
		status.sleeping     = (sl_q == SBSC_SL_SLEEP);
		aw_got_d = aw_got_q;
		awaddr_d = awaddr_q;
		w_got_d  = w_got_q;
		wdata_d  = wdata_q;
		wstrb_d  = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d  = bresp_q;
		recov_d  = recov_q;
		rvalid_d = rvalid_q;
		rdata_d  = rdata_q;
		rresp_d  = rresp_q;
		if (s_axi_awvalid && awready_q) begin
			aw_got_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_got_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (aw_got_q && w_got_q && !bvalid_q) begin
			aw_got_d = 1'b0;
			w_got_d  = 1'b0;
			bvalid_d = 1'b1;
			bresp_d  = `SBSC_RESP_OKAY;
			if (awaddr_q == `SBSC_OFF_RECOV) begin
				for (int b = 0; b < `SBSC_REC_W / `SBSC_BYTE_W; b++) begin
					if (wstrb_q[b]) begin
						recov_d[b*`SBSC_BYTE_W +: `SBSC_BYTE_W] = wdata_q[b*`SBSC_BYTE_W +: `SBSC_BYTE_W];
					end
				end
			end else if (awaddr_q != `SBSC_OFF_STATUS) begin
				bresp_d = `SBSC_RESP_SLVERR;
			end
		end
		awready_d = !aw_got_d && !bvalid_d;
		wready_d  = !w_got_d && !bvalid_d;
		if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid && arready_q) begin
			rvalid_d = 1'b1;
			rresp_d  = `SBSC_RESP_OKAY;
			if (s_axi_araddr == `SBSC_OFF_STATUS) begin
				rdata_d = status;
			end else if (s_axi_araddr == `SBSC_OFF_RECOV) begin
				rdata_d = {{(32 - `SBSC_REC_W){1'b0}}, recov_q};
			end else begin
				rdata_d = '0;
				rresp_d = `SBSC_RESP_SLVERR;
			end
		end
		arready_d = !rvalid_d;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q  <= 1'b0;
			awaddr_q  <= '0;
			w_got_q   <= 1'b0;
			wdata_q   <= '0;
			wstrb_q   <= '0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `SBSC_RESP_OKAY;
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= `SBSC_RESP_OKAY;
			recov_q   <= `SBSC_REC_W'(`SBSC_ZZR_CYCLES);
		end else begin
			aw_got_q  <= aw_got_d;
			awaddr_q  <= awaddr_d;
			w_got_q   <= w_got_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			awready_q <= awready_d;
			wready_q  <= wready_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
			recov_q   <= recov_d;
		end
	end
	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
endmodule // sbsc_top

/* bench/sbsc_checker.sv */
// Concurrent checks on the SRAM command, data and status ports of the controller.
`timescale 1ns/10ps
module sbsc_checker (
	input wire logic                 aclk,
	input wire logic                 aresetn,
	input wire logic                 s_axi_awready,
	input wire logic                 s_axi_wready,
	input wire logic                 s_axi_bvalid,
	input wire logic                 s_axi_bready,
	input wire logic                 s_axi_arvalid,
	input wire logic                 s_axi_arready,
	input wire logic                 s_axi_rvalid,
	input wire logic                 advance_or_load,
	input wire logic                 clk_enable_n,
	input wire logic                 chip_en1_n,
	input wire logic                 chip_en2,
	input wire logic                 chip_en3_n,
	input wire logic                 write_en_n,
	input wire sbsc_pkg::sbsc_data_t dq_out,
	input wire logic                 dq_oe,
	input wire logic                 sleep_request,
	input wire logic                 flow_through_select_n
);
	import sbsc_pkg::*;
	logic [3:0] quiet_q, quiet_d, asleep_q, asleep_d;
	// Commands are judged only once the sleep synchroniser and recovery have surely settled.
	wire        awake = (quiet_q == 4'hf);
	wire        sel = !clk_enable_n && !advance_or_load && !chip_en1_n && chip_en2 && !chip_en3_n;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	always_comb begin
		quiet_d = sleep_request ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
		asleep_d = !sleep_request ? 4'h0 : asleep_q + {3'h0, asleep_q != 4'hf};
	end
	always_ff @(posedge aclk) begin
		quiet_q <= aresetn ? quiet_d : 4'h0;
		asleep_q <= aresetn ? asleep_d : 4'h0;
	end
	sequence read_load;
		sel && write_en_n;
	endsequence
	sequence write_load;
		sel && !write_en_n;
	endsequence
	a_hold_keeps_bus: assert property (awake && clk_enable_n |=> $stable(dq_out) && $stable(dq_oe))
		else $error("data bus moved on a held edge");
	a_hold_keeps_read: assert property (awake && dq_oe && clk_enable_n |=> dq_oe)
		else $error("read stopped driving during a hold");
	a_pipe_read_lag: assert property (awake && flow_through_select_n ##0 read_load ##1 !clk_enable_n
		|=> dq_oe)
		else $error("pipelined read not driven after second edge");
	a_flow_read_now: assert property (awake && !flow_through_select_n ##0 read_load |=> dq_oe)
		else $error("flow-through read not driven after command edge");
	a_write_bus_off: assert property (awake && flow_through_select_n ##0 write_load ##1 !clk_enable_n
		|=> !dq_oe)
		else $error("bus driven in a write slot");
	a_sleep_floats_bus: assert property (asleep_q >= 4'h8 |-> !dq_oe)
		else $error("bus driven while asleep");
	a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_busy_no_aw: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("new write accepted before response");
endmodule // sbsc_checker

bind sbsc_top sbsc_checker u_checker (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .advance_or_load(advance_or_load), .clk_enable_n(clk_enable_n),
	.chip_en1_n(chip_en1_n), .chip_en2(chip_en2), .chip_en3_n(chip_en3_n),
	.write_en_n(write_en_n), .dq_out(dq_out), .dq_oe(dq_oe), .sleep_request(sleep_request),
	.flow_through_select_n(flow_through_select_n));

/* bench/sbsc_host_model.sv */
// Host memory controller that issues five-beat SRAM bursts.
`timescale 1ns/10ps
module sbsc_host_model (
	input  wire logic                 aclk,
	input  wire sbsc_pkg::sbsc_data_t dq_out,
	output sbsc_pkg::sbsc_addr_t      sram_addr,
	output logic                      advance_or_load,
	output logic                      clk_enable_n,
	output logic                      chip_en1_n,
	output logic                      chip_en2,
	output logic                      chip_en3_n,
	output logic                      write_en_n,
	output sbsc_pkg::sbsc_be_t        byte_write_n,
	output sbsc_pkg::sbsc_data_t      dq_in
);
	import sbsc_pkg::*;
	initial begin
		{advance_or_load, clk_enable_n, chip_en1_n, chip_en2, chip_en3_n} = 5'h06;
		write_en_n = 1'b1;
		byte_write_n = 4'h0;
		dq_in = 32'h0000_0000;
		sram_addr = 4'h0;
	end
	// One load then four continues; the fifth beat lands on the start again.
	task automatic burst(input logic wr, input logic stall, input int lag, input sbsc_addr_t a,
		input sbsc_data_t d, output sbsc_data_t rd [5]);
		for (int i = 0; i <= lag + 5; i++) begin
			if (stall && i == 2) begin
				@(posedge aclk);
				clk_enable_n <= 1'b1;
			end
			@(posedge aclk);
			clk_enable_n <= 1'b0;
			if (i > lag && i <= lag + 5) rd[i - lag - 1] = dq_out;
			advance_or_load <= (i > 0 && i < 5);
			chip_en1_n <= (i >= 5);
			write_en_n <= !wr;
			sram_addr <= (i == 0) ? a : ~sram_addr;
			// Unused data slots toggle so stale values never pass for data.
			dq_in <= (i >= lag && i < lag + 5) ? d + 32'(i - lag) : ~dq_in;
		end
	endtask
endmodule // sbsc_host_model

/* bench/test_sram_burst_sleep_control.sv */
// Self-checking bench for bursts, modes, holds, sleep and the status port.
`timescale 1ns/10ps
`include "sbsc_defines.svh"
module test_sram_burst_sleep_control;
	import sbsc_pkg::*;
	logic        aclk, aresetn, sleep_request, burst_order_select, flow_through_select_n;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, dq_oe;
	logic        advance_or_load, clk_enable_n, chip_en1_n, chip_en2, chip_en3_n, write_en_n;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, seed;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	sbsc_addr_t  sram_addr, a;
	sbsc_be_t    byte_write_n;
	sbsc_data_t  dq_in, dq_out, rdat;
	sbsc_data_t  rd [5];
	int          miscompares, check_count, mem [16];

	sbsc_top u_dut (.*);
	sbsc_host_model u_host (.*);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic sbsc_addr_t beat(input sbsc_addr_t s, input int k, input logic il);
		return {s[3:2], il ? s[1:0] ^ 2'(k) : s[1:0] + 2'(k)};
	endfunction

	task automatic chk_data(input sbsc_data_t got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: data %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: response %h expected %h", $time, got, exp);
		end
	endtask

	task automatic axi_wr(input logic [31:0] ad, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		while (n >= 0) begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				n = -1;
			end
		end
		// One edge passes so that a following call never reassigns bready in the same step.
		@(posedge aclk);
	endtask

	task automatic axi_rd(input logic [31:0] ad, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		s_axi_araddr <= ad;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		while (n >= 0) begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				n = -1;
			end
		end
	endtask

	// Writes update the model only when the device is awake; reads compare every beat.
	task automatic run_burst(input logic wr, input logic stall, input logic ft, input logic il,
		input sbsc_addr_t s, input sbsc_data_t d, input logic live);
		u_host.burst(wr, stall, ft ? 1 : 2, s, d, rd);
		for (int k = 0; k < 5; k++) begin
			if (wr && live) mem[beat(s, k, il)] = d + 32'(k);
			else if (!wr) chk_data(rd[k], mem[beat(s, k, il)]);
		end
	endtask

	task automatic finish_test;
		$display("checks %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		miscompares++;
		$display("wrong value at %0t: run did not complete", $time);
		finish_test();
	end

	initial begin
		{aresetn, sleep_request, burst_order_select, flow_through_select_n} = 4'h1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		s_axi_wstrb = 4'hf;
		seed = 32'h0000_1b80;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (6) @(posedge aclk);
		axi_wr(`SBSC_OFF_RECOV, 32'h0000_0001, resp);
		chk_resp(resp, `SBSC_RESP_OKAY);
		axi_rd(`SBSC_OFF_RECOV, rdat, resp);
		chk_data(rdat, 32'h0000_0001);
		axi_wr(`SBSC_OFF_STATUS, 32'hffff_ffff, resp);
		chk_resp(resp, `SBSC_RESP_OKAY);
		axi_wr(32'h0000_0010, 32'h0000_0005, resp);
		chk_resp(resp, `SBSC_RESP_SLVERR);
		axi_rd(32'h0000_0008, rdat, resp);
		chk_resp(resp, `SBSC_RESP_SLVERR);
		chk_data(rdat, 32'h0000_0000);
		$display("status port test done");
		for (int m = 0; m < 4; m++) begin
			flow_through_select_n <= !m[1];
			burst_order_select <= m[0];
			repeat (8) @(posedge aclk);
			seed = lfsr(seed);
			a = seed[3:0];
			run_burst(1'b1, 1'b0, m[1], m[0], a, seed, 1'b1);
			seed = lfsr(seed);
			run_burst(1'b0, m == 0, m[1], m[0], {a[3:2], seed[5:4]}, seed, 1'b1);
			$display("burst test in mode %0d done", m);
		end
		sleep_request <= 1'b1;
		repeat (10) @(posedge aclk);
		axi_rd(`SBSC_OFF_STATUS, rdat, resp);
		chk_data(rdat & 32'h0000_0001, 32'h0000_0001);
		run_burst(1'b1, 1'b0, 1'b1, 1'b1, a, ~seed, 1'b0);
		sleep_request <= 1'b0;
		repeat (20) @(posedge aclk);
		axi_rd(`SBSC_OFF_STATUS, rdat, resp);
		chk_data(rdat & 32'h0000_0003, 32'h0000_0000);
		run_burst(1'b0, 1'b0, 1'b1, 1'b1, a, seed, 1'b1);
		$display("sleep test done");
		finish_test();
	end
endmodule // test_sram_burst_sleep_control
